// >>> design/expander_pkg.sv
// Constants and types shared by the I/O expander register and alert logic.
package expander_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS  = 50;
  localparam int SLOW_DETECT_MS = 32;
  localparam int FAST_DETECT_US = 200;
  localparam int SLOW_CYC = SLOW_DETECT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FAST_CYC = FAST_DETECT_US * 1000 / CLK_PERIOD_NS;
  // Synchroniser and compare latency taken off each sample period.
  localparam int SAMPLE_MARGIN = 3;
  // Cycles that SCL is held low while a byte is moved.
  localparam int PROC_CYC = 6;

  // ==========================================================================
  // Bus addressing and byte framing
  // ==========================================================================
  localparam logic [3:0] DEV_ADDR_HI = 4'h4;
  localparam logic [3:0] BIT_ACK     = 4'h8;
  localparam logic [3:0] BIT_DONE    = 4'h9;

  // ==========================================================================
  // Register map: command byte bits 7:1 pick the pair, bit 0 the byte
  // ==========================================================================
  localparam logic [6:0] PAIR_PORT = 7'h00;
  localparam logic [6:0] PAIR_LAT  = 7'h01;
  localparam logic [6:0] PAIR_POL  = 7'h02;
  localparam logic [6:0] PAIR_DIR  = 7'h03;
  localparam logic [6:0] PAIR_CAP  = 7'h04;
  localparam logic [6:0] PAIR_CTRL = 7'h05;
  localparam logic [7:0] REG_PORT_LO    = 8'h00;
  localparam logic [7:0] REG_LAT_HI     = 8'h03;
  localparam logic [7:0] REG_CTRL_ALIAS = 8'h0B;
  localparam int         ARS_BIT        = 0;

  localparam logic [15:0] LAT_RESET = 16'h0000;
  localparam logic [15:0] POL_RESET = 16'h0000;
  localparam logic [15:0] DIR_RESET = 16'hFFFF;
  localparam logic [7:0]  CMD_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CMD  = 3'b010,
    ST_WR   = 3'b011,
    ST_RD   = 3'b100,
    ST_SKIP = 3'b101
  } i2c_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_t;

endpackage

// >>> design/expander_core.sv
// Two-wire slave, register pairs and change alert of a 16-bit I/O expander.
`timescale 1ns/1ps

module expander_core #(
  parameter int SLOW_CYCLES = expander_pkg::SLOW_CYC,
  parameter int FAST_CYCLES = expander_pkg::FAST_CYC,
  parameter int DIV_W       = 20
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [2:0]  addr_pins,
  input  wire logic        scl_in,
  output      logic        scl_out,
  output      logic        scl_oe,
  input  wire logic        sda_in,
  output      logic        sda_out,
  output      logic        sda_oe,
  input  wire logic [15:0] port_in,
  output      logic [15:0] port_out,
  output      logic [15:0] port_oe,
  output      logic        alert_n_out,
  output      logic        alert_oe
);

  localparam logic [DIV_W-1:0] SLOW_LIM =
    DIV_W'(SLOW_CYCLES - expander_pkg::SAMPLE_MARGIN - 1);
  localparam logic [DIV_W-1:0] FAST_LIM =
    DIV_W'(FAST_CYCLES - expander_pkg::SAMPLE_MARGIN - 1);
  localparam logic [2:0] HOLD_LOAD = 3'(expander_pkg::PROC_CYC - 1);

  default clocking cb @(posedge clock iff clk_en); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  expander_pkg::bus_lines_t ln_m1_r, ln_s_r, ln_d_r;
  logic [15:0]              pin_m1_r, pin_s_r;
  logic [2:0]               adr_m1_r, adr_s_r;
  logic                     scl_rise, scl_fall, start_c, stop_c;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ln_m1_r  <= '1;
      ln_s_r   <= '1;
      ln_d_r   <= '1;
      pin_m1_r <= '0;
      pin_s_r  <= '0;
      adr_m1_r <= '0;
      adr_s_r  <= '0;
    end else if (clk_en) begin
      ln_m1_r  <= {scl_in, sda_in};
      ln_s_r   <= ln_m1_r;
      ln_d_r   <= ln_s_r;
      pin_m1_r <= port_in;
      pin_s_r  <= pin_m1_r;
      adr_m1_r <= addr_pins;
      adr_s_r  <= adr_m1_r;
    end
  end

  assign scl_rise = ln_s_r.scl & ~ln_d_r.scl;
  assign scl_fall = ~ln_s_r.scl & ln_d_r.scl;
  assign start_c  = ln_s_r.scl & ln_d_r.scl & ~ln_s_r.sda & ln_d_r.sda;
  assign stop_c   = ln_s_r.scl & ln_d_r.scl & ln_s_r.sda & ~ln_d_r.sda;

  // ==========================================================================
  // Port sampler
  // ==========================================================================
  // Sampling only at the tick keeps the scan rate, and so the power, low.
  logic [DIV_W-1:0] div_r, div_nxt, lim;
  logic [15:0]      samp_r, samp_nxt;
  logic             armed_r, armed_nxt, tick;
  logic             ars_r;
  logic [15:0]      pol_r, dir_r;

  always_comb begin
    lim       = ars_r ? FAST_LIM : SLOW_LIM;
    tick      = (div_r >= lim);
    div_nxt   = tick ? '0 : div_r + 1'b1;
    samp_nxt  = tick ? (pin_s_r ^ pol_r) : samp_r;
    armed_nxt = armed_r | tick;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_r   <= '0;
      samp_r  <= '0;
      armed_r <= 1'b0;
    end else if (clk_en) begin
      div_r   <= div_nxt;
      samp_r  <= samp_nxt;
      armed_r <= armed_nxt;
    end
  end

  property p_slow_rate;
    !ars_r |-> div_r <= SLOW_LIM;
  endproperty
  a_slow_rate: assert property (p_slow_rate)
    else $error("slow sample period exceeded");

  property p_fast_rate;
    (ars_r && $past(ars_r)) |-> div_r <= FAST_LIM;
  endproperty
  a_fast_rate: assert property (p_fast_rate)
    else $error("fast sample period exceeded");

  // ==========================================================================
  // Bus slave and register file
  // ==========================================================================
  expander_pkg::i2c_state_t st_r, st_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic [7:0]  sh_r, sh_nxt, tx_r, tx_nxt, cmd_r, cmd_nxt, ptr_r, ptr_nxt;
  logic [7:0]  sel, rd_byte, ctrl_byte;
  logic [15:0] pair, lat_r, lat_nxt, pol_nxt, dir_nxt;
  logic [2:0]  hcnt_r, hcnt_nxt;
  logic        hold_r, hold_nxt, mack_r, mack_nxt, rw_r, rw_nxt;
  logic        oe_r, oe_nxt, ars_nxt, wr_en, fetch;
  logic [1:0]  clr;
  logic [1:0][7:0] cap_r;

  always_comb begin
    sel       = (st_r == expander_pkg::ST_ADDR) ? cmd_r : ptr_r;
    ctrl_byte = 8'h00;
    ctrl_byte[expander_pkg::ARS_BIT] = ars_r;
    case (sel[7:1])
      expander_pkg::PAIR_PORT: pair = pin_s_r ^ pol_r;
      expander_pkg::PAIR_LAT:  pair = lat_r;
      expander_pkg::PAIR_POL:  pair = pol_r;
      expander_pkg::PAIR_DIR:  pair = dir_r;
      expander_pkg::PAIR_CAP:  pair = {cap_r[1], cap_r[0]};
      expander_pkg::PAIR_CTRL: pair = {ctrl_byte, ctrl_byte};
      default:                 pair = '0;
    endcase
    rd_byte = sel[0] ? pair[15:8] : pair[7:0];

    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    sh_nxt   = sh_r;
    tx_nxt   = tx_r;
    cmd_nxt  = cmd_r;
    ptr_nxt  = ptr_r;
    hold_nxt = hold_r;
    hcnt_nxt = hcnt_r;
    mack_nxt = mack_r;
    rw_nxt   = rw_r;
    oe_nxt   = oe_r;
    lat_nxt  = lat_r;
    pol_nxt  = pol_r;
    dir_nxt  = dir_r;
    ars_nxt  = ars_r;
    wr_en    = 1'b0;
    fetch    = 1'b0;

    if (start_c) begin
      st_nxt  = expander_pkg::ST_ADDR;
      cnt_nxt = '0;
      oe_nxt  = 1'b0;
    end else if (stop_c) begin
      st_nxt  = expander_pkg::ST_IDLE;
      oe_nxt  = 1'b0;
    end else if (hold_r) begin
      hcnt_nxt = hcnt_r - 3'h1;
      hold_nxt = (hcnt_r != 3'h0);
    end else if (scl_rise && st_r != expander_pkg::ST_IDLE) begin
      if (cnt_r == expander_pkg::BIT_ACK) begin
        mack_nxt = ln_s_r.sda;
        cnt_nxt  = expander_pkg::BIT_DONE;
      end else begin
        sh_nxt  = {sh_r[6:0], ln_s_r.sda};
        cnt_nxt = cnt_r + 4'h1;
      end
    end else if (scl_fall && st_r != expander_pkg::ST_IDLE) begin
      if (cnt_r == expander_pkg::BIT_ACK) begin
        case (st_r)
          expander_pkg::ST_ADDR: begin
            if (sh_r[7:1] == {expander_pkg::DEV_ADDR_HI, adr_s_r}) begin
              oe_nxt = 1'b1;
              rw_nxt = sh_r[0];
            end else begin
              st_nxt = expander_pkg::ST_SKIP;
            end
          end
          expander_pkg::ST_CMD, expander_pkg::ST_WR: oe_nxt = 1'b1;
          default: oe_nxt = 1'b0;
        endcase
      end else if (cnt_r == expander_pkg::BIT_DONE) begin
        cnt_nxt = '0;
        oe_nxt  = 1'b0;
        case (st_r)
          expander_pkg::ST_ADDR: begin
            if (rw_r) begin
              st_nxt = expander_pkg::ST_RD;
              fetch  = 1'b1;
            end else begin
              st_nxt = expander_pkg::ST_CMD;
            end
          end
          expander_pkg::ST_CMD: begin
            cmd_nxt = sh_r;
            ptr_nxt = sh_r;
            st_nxt  = expander_pkg::ST_WR;
          end
          expander_pkg::ST_WR: wr_en = 1'b1;
          expander_pkg::ST_RD: begin
            if (!mack_r) begin
              fetch = 1'b1;
            end else begin
              st_nxt = expander_pkg::ST_SKIP;
            end
          end
          default: st_nxt = st_r;
        endcase
      end else if (st_r == expander_pkg::ST_RD && cnt_r != 4'h0) begin
        tx_nxt = {tx_r[6:0], 1'b0};
        oe_nxt = ~tx_r[6];
      end
    end

    if (fetch) begin
      tx_nxt = rd_byte;
      oe_nxt = ~rd_byte[7];
    end
    if (wr_en) begin
      case (sel[7:1])
        expander_pkg::PAIR_PORT, expander_pkg::PAIR_LAT: begin
          if (sel[0]) lat_nxt[15:8] = sh_r;
          else lat_nxt[7:0] = sh_r;
        end
        expander_pkg::PAIR_POL: begin
          if (sel[0]) pol_nxt[15:8] = sh_r;
          else pol_nxt[7:0] = sh_r;
        end
        expander_pkg::PAIR_DIR: begin
          if (sel[0]) dir_nxt[15:8] = sh_r;
          else dir_nxt[7:0] = sh_r;
        end
        expander_pkg::PAIR_CTRL: ars_nxt = sh_r[expander_pkg::ARS_BIT];
        default: ars_nxt = ars_r;
      endcase
    end
    if (fetch || wr_en) begin
      ptr_nxt  = {sel[7:1], ~sel[0]};
      hold_nxt = 1'b1;
      hcnt_nxt = HOLD_LOAD;
    end
    for (int g = 0; g < 2; g++) begin
      clr[g] = fetch && (sel[0] == 1'(g)) &&
               (sel[7:1] == expander_pkg::PAIR_PORT ||
                sel[7:1] == expander_pkg::PAIR_CAP);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r   <= expander_pkg::ST_IDLE;
      cnt_r  <= '0;
      sh_r   <= '0;
      tx_r   <= '0;
      cmd_r  <= expander_pkg::CMD_RESET;
      ptr_r  <= expander_pkg::CMD_RESET;
      hold_r <= 1'b0;
      hcnt_r <= '0;
      mack_r <= 1'b1;
      rw_r   <= 1'b0;
      oe_r   <= 1'b0;
      lat_r  <= expander_pkg::LAT_RESET;
      pol_r  <= expander_pkg::POL_RESET;
      dir_r  <= expander_pkg::DIR_RESET;
      ars_r  <= 1'b0;
    end else if (clk_en) begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      sh_r   <= sh_nxt;
      tx_r   <= tx_nxt;
      cmd_r  <= cmd_nxt;
      ptr_r  <= ptr_nxt;
      hold_r <= hold_nxt;
      hcnt_r <= hcnt_nxt;
      mack_r <= mack_nxt;
      rw_r   <= rw_nxt;
      oe_r   <= oe_nxt;
      lat_r  <= lat_nxt;
      pol_r  <= pol_nxt;
      dir_r  <= dir_nxt;
      ars_r  <= ars_nxt;
    end
  end

  property p_ctrl_read;
    (fetch && sel[7:1] == expander_pkg::PAIR_CTRL)
      |=> tx_r == {7'h00, $past(ars_r)};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control readback upper bits not zero");

  property p_alias;
    (wr_en && ptr_r == expander_pkg::REG_CTRL_ALIAS)
      |=> ars_r == $past(sh_r[expander_pkg::ARS_BIT]);
  endproperty
  a_alias: assert property (p_alias)
    else $error("alias write did not reach control");

  property p_pair_toggle;
    wr_en |=> ptr_r == {$past(ptr_r[7:1]), ~$past(ptr_r[0])};
  endproperty
  a_pair_toggle: assert property (p_pair_toggle)
    else $error("pointer did not move to pair partner");

  property p_high_latch;
    (wr_en && ptr_r == expander_pkg::REG_LAT_HI)
      |=> lat_r[15:8] == $past(sh_r) && $stable(lat_r[7:0]);
  endproperty
  a_high_latch: assert property (p_high_latch)
    else $error("high latch write misdirected");

  property p_stretch;
    (wr_en || fetch) |=> hold_r [*6] ##1 !hold_r;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("SCL hold length wrong");

  // ==========================================================================
  // Change detection and capture, one lane per 8-bit port
  // ==========================================================================
  logic [1:0][7:0] ref_r, ref_nxt, cap_nxt;
  logic [1:0]      int_r, int_nxt, pend;

  always_comb begin
    for (int g = 0; g < 2; g++) begin
      pend[g]    = |((samp_r[g*8 +: 8] ^ ref_r[g]) & dir_r[g*8 +: 8]);
      ref_nxt[g] = ref_r[g];
      cap_nxt[g] = cap_r[g];
      int_nxt[g] = pend[g];
      // A change first seen in the cycle of a clearing read wins over it,
      // otherwise the reference would swallow the change unflagged.
      if (!armed_r) begin
        ref_nxt[g] = samp_nxt[g*8 +: 8];
        int_nxt[g] = 1'b0;
      end else if (pend[g] && !int_r[g]) begin
        cap_nxt[g] = samp_r[g*8 +: 8];
      end else if (clr[g]) begin
        ref_nxt[g] = samp_r[g*8 +: 8];
        int_nxt[g] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ref_r <= '0;
      cap_r <= '0;
      int_r <= '0;
    end else if (clk_en) begin
      ref_r <= ref_nxt;
      cap_r <= cap_nxt;
      int_r <= int_nxt;
    end
  end

  property p_out_pins;
    (dir_r[7:0] == 8'h00) |=> !int_r[0];
  endproperty
  a_out_pins: assert property (p_out_pins)
    else $error("output pins raised the alert");

  property p_hold_alert;
    (int_r[1] && pend[1] && !clr[1]) |=> int_r[1];
  endproperty
  a_hold_alert: assert property (p_hold_alert)
    else $error("alert dropped without a clearing read");

  property p_revert;
    (int_r[0] && !pend[0]) |=> !int_r[0];
  endproperty
  a_revert: assert property (p_revert)
    else $error("reverted input left the alert set");

  property p_port_sep;
    (fetch && sel == expander_pkg::REG_PORT_LO) |=> int_r[1] == $past(pend[1]);
  endproperty
  a_port_sep: assert property (p_port_sep)
    else $error("low port read touched high port alert");

  property p_capture;
    (armed_r && !int_r[0] && pend[0] && !clr[0])
      |=> cap_r[0] == $past(samp_r[7:0]) && int_r[0];
  endproperty
  a_capture: assert property (p_capture)
    else $error("port change not captured");

  property p_no_recapture;
    int_r[1] |=> $stable(cap_r[1]);
  endproperty
  a_no_recapture: assert property (p_no_recapture)
    else $error("capture changed while alert pending");

  // ==========================================================================
  // Pin drivers
  // ==========================================================================
  assign scl_out     = 1'b0;
  assign scl_oe      = hold_r;
  assign sda_out     = 1'b0;
  assign sda_oe      = oe_r;
  assign port_out    = lat_r;
  assign port_oe     = ~dir_r;
  assign alert_n_out = 1'b0;
  assign alert_oe    = |int_r;

endmodule

// >>> verification/i2c_master_model.sv
// Two-wire bus master model that drives the expander from the far side.
`timescale 1ns/1ps
module i2c_master_model (
  input  wire logic       clock,
  input  wire logic       scl_w,
  input  wire logic       sda_w,
  output      logic       scl_pull,
  output      logic       sda_pull,
  output      logic       rd_strobe,
  output      logic [7:0] rd_data
);
  // ====================
  // Bus phases
  initial begin
    scl_pull  = 1'b0;
    sda_pull  = 1'b0;
    rd_strobe = 1'b0;
    rd_data   = 8'h00;
  end

  task automatic tk(input int n);
    repeat (n) @(negedge clock);
  endtask

  // The device may stretch the clock, so wait for the wire, not a timer.
  task automatic rise();
    int n;
    n = 0;
    scl_pull = 1'b0;
    while (scl_w !== 1'b1 && n < 64) begin
      tk(1);
      n++;
    end
  endtask

  task automatic bit_io(input logic b, output logic r);
    tk(2);
    sda_pull = ~b;
    tk(2);
    rise();
    tk(2);
    r = sda_w;
    tk(2);
    scl_pull = 1'b1;
  endtask

  // Serves as plain and as repeated start.
  task automatic start_c();
    tk(2);
    sda_pull = 1'b0;
    tk(2);
    rise();
    tk(4);
    sda_pull = 1'b1;
    tk(4);
    scl_pull = 1'b1;
  endtask

  task automatic stop_c();
    tk(2);
    sda_pull = 1'b1;
    tk(2);
    rise();
    tk(4);
    sda_pull = 1'b0;
    tk(4);
  endtask

  task automatic xfer(input logic [7:0] d, input logic b9,
                      input logic rd, output logic ack);
    logic       r;
    logic [7:0] q;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(b9, r);
    ack = ~r;
    tk(1);
    sda_pull = 1'b0;
    rd_data = q;
    rd_strobe = rd;
    tk(1);
    rd_strobe = 1'b0;
    // The device moves data while the master keeps SCL low and waits.
    tk(238);
  endtask
endmodule

// >>> verification/tb_i2c_port_expander_irq_regs.sv
// Self-checking bench for the expander's bus registers and change alert.
`timescale 1ns/1ps
module tb_i2c_port_expander_irq_regs;
  localparam int SLOW = 200;
  localparam int FAST = 50;
  logic        clock, rst_n, scl_out, scl_oe, sda_out, sda_oe;
  logic        alert_n_out, alert_oe, m_scl, m_sda, rd_strobe, clk_en;
  logic [2:0]  addr;
  logic [7:0]  rd_data, lat_hi;
  logic [15:0] port_in, port_out, port_oe, pin_drv;
  wire         scl_w = (scl_oe ? scl_out : 1'b1) & ~m_scl;
  wire         sda_w = (sda_oe ? sda_out : 1'b1) & ~m_sda;
  wire         alert_w = alert_oe ? alert_n_out : 1'b1;
  int          bad_count = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          hold_len = 0;
  logic [7:0]  exp_q[$];

  // Output pins show the latch, input pins what the bench drives.
  assign port_in = (port_out & port_oe) | (pin_drv & ~port_oe);

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  expander_core #(
    .SLOW_CYCLES (SLOW),
    .FAST_CYCLES (FAST)
  ) uut (
    .clock       (clock),
    .rst_n       (rst_n),
    .clk_en      (clk_en),
    .addr_pins   (addr),
    .scl_in      (scl_w),
    .scl_out     (scl_out),
    .scl_oe      (scl_oe),
    .sda_in      (sda_w),
    .sda_out     (sda_out),
    .sda_oe      (sda_oe),
    .port_in     (port_in),
    .port_out    (port_out),
    .port_oe     (port_oe),
    .alert_n_out (alert_n_out),
    .alert_oe    (alert_oe)
  );

  i2c_master_model m (
    .clock     (clock),
    .scl_w     (scl_w),
    .sda_w     (sda_w),
    .scl_pull  (m_scl),
    .sda_pull  (m_sda),
    .rd_strobe (rd_strobe),
    .rd_data   (rd_data)
  );

  // ====================
  // Checking
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    if (rd_strobe === 1'b1 && exp_q.size() > 0) begin
      check_byte(rd_data, exp_q.pop_front());
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      $display("Run stopped by the cycle limit");
      conclude();
    end
  end

  // Every SCL stretch must last the fixed hold, counted at falling edges.
  always @(negedge clock) begin
    if (scl_oe === 1'b1) begin
      hold_len++;
    end else if (hold_len != 0) begin
      check_val(16'(hold_len), 16'(expander_pkg::PROC_CYC));
      hold_len = 0;
    end
  end

  // ====================
  // Bus transfers
  function automatic logic [7:0] ab(input logic rw);
    return {expander_pkg::DEV_ADDR_HI, addr, rw};
  endfunction

  task automatic wr(input logic [7:0] cmd, input logic [7:0] d[$]);
    logic ack;
    m.start_c();
    m.xfer(ab(1'b0), 1'b1, 1'b0, ack);
    check_val(16'(ack), 16'h0001);
    m.xfer(cmd, 1'b1, 1'b0, ack);
    foreach (d[i]) m.xfer(d[i], 1'b1, 1'b0, ack);
    m.stop_c();
  endtask

  task automatic rd(input logic [7:0] cmd, input logic [7:0] e[$]);
    logic ack;
    m.start_c();
    m.xfer(ab(1'b0), 1'b1, 1'b0, ack);
    m.xfer(cmd, 1'b1, 1'b0, ack);
    m.start_c();
    m.xfer(ab(1'b1), 1'b1, 1'b0, ack);
    check_val(16'(ack), 16'h0001);
    foreach (e[i]) begin
      exp_q.push_back(e[i]);
      m.xfer(8'hFF, i == e.size() - 1, 1'b1, ack);
    end
    m.stop_c();
  endtask

  task automatic wait_alert(input logic lvl, input int lim);
    int n;
    n = 0;
    while (alert_w !== lvl && n < lim) begin
      @(negedge clock);
      n++;
    end
    check_val(16'(alert_w), 16'(lvl));
  endtask

  // ====================
  // Tests
  initial begin
    logic [7:0] a, b, c, lo, hi, e0, e1;
    logic       ack;
    rst_n = 1'b0;
    clk_en = 1'b1;
    pin_drv = 16'h0000;
    void'($urandom(32'h83E0F51D));
    addr = 3'($urandom());
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    check_val(port_oe, 16'h0000);
    check_val(port_out, 16'h0000);
    rd(8'h06, {8'hFF, 8'hFF});
    rd(8'h0A, {8'h00});
    $display("Test reset values done");
    m.start_c();
    m.xfer(ab(1'b0) ^ 8'h02, 1'b1, 1'b0, ack);
    m.stop_c();
    check_val(16'(ack), 16'h0000);
    $display("Test wrong address done");
    for (int k = 0; k < 2; k++) begin
      a = 8'($urandom());
      b = 8'($urandom());
      c = 8'($urandom());
      wr(8'h02 + 8'(k), {a, b, c});
      lo = k ? b : c;
      hi = k ? c : b;
      e0 = k ? hi : lo;
      e1 = k ? lo : hi;
      check_val(port_out, {hi, lo});
      rd(8'h02 + 8'(k), {e0, e1, e0});
    end
    lat_hi = hi;
    $display("Test latch pairs done");
    wr(8'h0B, {8'hFF});
    rd(8'h0A, {8'h01});
    rd(8'h0B, {8'h01});
    $display("Test control alias done");
    wr(8'h08, {8'h5A, 8'hA5});
    wr(8'h06, {8'hFF, 8'h0F});
    check_val(port_oe, 16'hF000);
    lat_hi = ~lat_hi;
    wr(8'h03, {lat_hi});
    repeat (2 * FAST) @(negedge clock);
    check_val(16'(alert_w), 16'h0001);
    $display("Test output pins quiet done");
    pin_drv[0] = 1'b1;
    wait_alert(1'b0, FAST + 8);
    pin_drv[1] = 1'b1;
    repeat (2 * FAST) @(negedge clock);
    rd(8'h08, {8'h01});
    check_val(16'(alert_w), 16'h0001);
    repeat (2 * FAST) @(negedge clock);
    check_val(16'(alert_w), 16'h0001);
    $display("Test capture done");
    pin_drv[2] = 1'b1;
    wait_alert(1'b0, FAST + 8);
    pin_drv[2] = 1'b0;
    wait_alert(1'b1, FAST + 8);
    rd(8'h08, {8'h07});
    pin_drv[3] = 1'b1;
    wait_alert(1'b0, FAST + 8);
    rd(8'h08, {8'h0B});
    $display("Test revert done");
    pin_drv[8] = 1'b1;
    wait_alert(1'b0, FAST + 8);
    rd(8'h00, {8'h0B});
    check_val(16'(alert_w), 16'h0000);
    rd(8'h01, {{lat_hi[7:4], 4'h1}});
    check_val(16'(alert_w), 16'h0001);
    $display("Test per port done");
    wr(8'h0A, {8'h00});
    pin_drv[9] = 1'b1;
    wait_alert(1'b0, SLOW + 8);
    rd(8'h09, {{lat_hi[7:4], 4'h3}});
    check_val(16'(alert_w), 16'h0001);
    $display("Test slow rate done");
    // With the enable low nothing may move, so the pin change stays unseen.
    clk_en = 1'b0;
    pin_drv[10] = 1'b1;
    repeat (2 * SLOW) @(negedge clock);
    check_val(16'(alert_w), 16'h0001);
    clk_en = 1'b1;
    wait_alert(1'b0, SLOW + 8);
    rd(8'h09, {{lat_hi[7:4], 4'h7}});
    check_val(16'(alert_w), 16'h0001);
    $display("Test clock enable done");
    // Inversion only on output pins, so no alert is raised by it.
    wr(8'h05, {8'hF0, 8'h00});
    exp_q.push_back(8'hF0);
    m.start_c();
    m.xfer(ab(1'b1), 1'b1, 1'b0, ack);
    check_val(16'(ack), 16'h0001);
    m.xfer(8'hFF, 1'b1, 1'b1, ack);
    m.stop_c();
    rd(8'h04, {8'h00, 8'hF0});
    rd(8'h01, {{~lat_hi[7:4], 4'h7}});
    check_val(16'(alert_w), 16'h0001);
    $display("Test polarity done");
    check_val(16'(exp_q.size()), 16'h0000);
    conclude();
  end
endmodule
